// ==== rtl/dcpwm_pkg.sv ====
/*
 * constants, configuration carrier and state types of the dual channel pulse group
 * assumes a 50 mhz system clock; the 16 mhz controller base rate is derived from it
 */
`default_nettype none

package dcpwm_pkg;

	// clocking
	localparam int          CLOCK_HZ     = 50_000_000;
	localparam int          BASE_HZ      = 16_000_000;
	localparam int          TICK_UNIT_HZ = 1_000_000;
	localparam logic [5:0]  TICK_STEP    = 6'(BASE_HZ / TICK_UNIT_HZ);
	localparam logic [5:0]  TICK_MOD     = 6'(CLOCK_HZ / TICK_UNIT_HZ);

	// group control byte layout, pin setup sensor field and reset values
	localparam int          MODE_LSB     = 0;
	localparam int          EN_A_BIT     = 3;
	localparam int          EN_B_BIT     = 4;
	localparam int          DIV_LSB      = 5;
	localparam int          SENSOR_LSB   = 4;
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [15:0] PERIOD_RESET = 16'h0000;

	// divider select codes and group tick targets (two base ticks per divider step)
	localparam logic [2:0]  DIV_OFF      = 3'h0;
	localparam logic [2:0]  DIV_X1       = 3'h1;
	localparam logic [2:0]  DIV_X8       = 3'h2;
	localparam logic [2:0]  DIV_X64      = 3'h3;
	localparam logic [2:0]  DIV_X256     = 3'h4;
	localparam logic [11:0] PRE_X1       = 12'h002;
	localparam logic [11:0] PRE_X8       = 12'h010;
	localparam logic [11:0] PRE_X64      = 12'h080;
	localparam logic [11:0] PRE_X256     = 12'h200;
	localparam logic [11:0] PRE_X1024    = 12'h800;

	// servo waveform in microsecond ticks
	localparam logic [11:0] SERVO_PRE    = 12'(BASE_HZ / TICK_UNIT_HZ);
	localparam logic [15:0] SERVO_FRAME  = 16'h4e20;
	localparam logic [15:0] SERVO_MIN    = 16'h03e8;
	localparam logic [15:0] SERVO_SPAN   = 16'h03e8;

	typedef enum logic [1:0] {
		MODE_SERVO = 2'h0,
		MODE_DUTY  = 2'h1,
		MODE_UNIV  = 2'h2,
		MODE_FREQ  = 2'h3
	} dcpwm_mode_t;

	typedef struct packed {
		logic [7:0]  control;
		logic [7:0]  period_low;
		logic [7:0]  period_high;
		logic [15:0] duty_a;
		logic [15:0] duty_b;
	} dcpwm_cfg_t;

	typedef struct packed {
		logic [7:0]  ctrl;
		logic [15:0] period;
		logic [15:0] duty_a;
		logic [15:0] duty_b;
		dcpwm_mode_t act_mode;
		logic [2:0]  act_div;
		logic [15:0] act_period;
		logic [15:0] act_duty_a;
		logic [15:0] act_duty_b;
		logic [11:0] pre;
		logic [15:0] cnt;
		logic [15:0] cnt_b;
		logic        tog_a;
		logic        tog_b;
		logic        out_a;
		logic        out_b;
		logic        lockout;
	} dcpwm_group_t;

	typedef struct packed {
		logic [5:0] acc;
		logic       tick;
	} dcpwm_top_t;

	localparam dcpwm_group_t GROUP_RESET = '0;
	localparam dcpwm_top_t   TOP_RESET   = '0;

endpackage

`default_nettype wire

// ==== rtl/dcpwm_top.sv ====
/*
 * three dual channel pulse groups and the shared 16 mhz base tick
 * assumes all inputs synchronous to i_clock; i_write pulses once per host exchange
 */
// Functional notes
// - two-bit mode field, servo after reset
// - servo mode drives servo frame waveform
// - duty mode: common frequency, separate duties
// - universal: B half frequency, 50% duty
// - frequency mode: free frequencies, 50% duty
// - bits 3/4 enable channels, clear at reset
// - configure and enable in one exchange
// - divider select decode, 000 turns off
// - divider rate ignored in servo mode, 000 still turns off
// - sensors active refuse frequency mode, outputs off
// - 16-bit period word shared by both channels
// - frequency mode ignores period word
// - duty per channel; universal only A
// - output frequency base/2/divider/period
// - three groups of two 16-bit channels
// - upper pin setup nibble selects sensors
`default_nettype none

module dcpwm_group (
	// clock and reset
	input  wire logic               i_clock,
	input  wire logic               i_reset_n,
	// timing and configuration
	input  wire logic               i_base_tick,
	input  wire logic               i_write,
	input  wire dcpwm_pkg::dcpwm_cfg_t i_cfg,
	input  wire logic               i_sensor_any,
	// outputs
	output logic                    o_out_a,
	output logic                    o_out_b,
	output logic                    o_lockout
);

	dcpwm_pkg::dcpwm_group_t st_reg;
	dcpwm_pkg::dcpwm_group_t st_next;
	logic                    lock;
	logic                    req_off;
	logic                    act_run;
	logic                    gtick;
	logic                    wrap_a;
	logic                    wrap_b;
	logic                    wave_a;
	logic                    wave_b;
	logic [11:0]             target;
	logic [15:0]             limit_a;
	logic [11:0]             div_target;
	logic [15:0]             servo_a;
	logic [15:0]             servo_b;

	assign lock    = (st_reg.ctrl[dcpwm_pkg::MODE_LSB +: 2] == dcpwm_pkg::MODE_FREQ) && i_sensor_any;
	assign req_off = (st_reg.ctrl[dcpwm_pkg::DIV_LSB +: 3] == dcpwm_pkg::DIV_OFF)
		|| (st_reg.act_div == dcpwm_pkg::DIV_OFF) || lock;
	assign act_run = !req_off && (st_reg.ctrl[dcpwm_pkg::EN_A_BIT] || st_reg.ctrl[dcpwm_pkg::EN_B_BIT]);
	assign target  = (st_reg.act_mode == dcpwm_pkg::MODE_SERVO) ? dcpwm_pkg::SERVO_PRE
		: div_target;
	assign gtick   = i_base_tick && (st_reg.pre == target - 12'h001);
	assign limit_a = (st_reg.act_mode == dcpwm_pkg::MODE_SERVO) ? dcpwm_pkg::SERVO_FRAME
		: (st_reg.act_mode == dcpwm_pkg::MODE_FREQ) ? st_reg.act_duty_a : st_reg.act_period;
	assign wrap_a  = (limit_a == 16'h0000) || (st_reg.cnt >= limit_a - 16'h0001);
	assign wrap_b  = (st_reg.act_duty_b == 16'h0000) || (st_reg.cnt_b >= st_reg.act_duty_b - 16'h0001);
	assign servo_a = dcpwm_pkg::SERVO_MIN
		+ ((st_reg.act_duty_a > dcpwm_pkg::SERVO_SPAN) ? dcpwm_pkg::SERVO_SPAN : st_reg.act_duty_a);
	assign servo_b = dcpwm_pkg::SERVO_MIN
		+ ((st_reg.act_duty_b > dcpwm_pkg::SERVO_SPAN) ? dcpwm_pkg::SERVO_SPAN : st_reg.act_duty_b);

	// group tick target per divider select
	always_comb begin
		case (st_reg.act_div)
			dcpwm_pkg::DIV_X1: begin
				div_target = dcpwm_pkg::PRE_X1;
			end
			dcpwm_pkg::DIV_X8: begin
				div_target = dcpwm_pkg::PRE_X8;
			end
			dcpwm_pkg::DIV_X64: begin
				div_target = dcpwm_pkg::PRE_X64;
			end
			dcpwm_pkg::DIV_X256: begin
				div_target = dcpwm_pkg::PRE_X256;
			end
			default: begin
				div_target = dcpwm_pkg::PRE_X1024;
			end
		endcase
	end

	// waveform per mode
	always_comb begin
		case (st_reg.act_mode)
			dcpwm_pkg::MODE_SERVO: begin
				wave_a = st_reg.cnt < servo_a;
				wave_b = st_reg.cnt < servo_b;
			end
			dcpwm_pkg::MODE_DUTY: begin
				wave_a = (st_reg.act_period != 16'h0000) && (st_reg.cnt < st_reg.act_duty_a);
				wave_b = (st_reg.act_period != 16'h0000) && (st_reg.cnt < st_reg.act_duty_b);
			end
			dcpwm_pkg::MODE_UNIV: begin
				wave_a = (st_reg.act_period != 16'h0000) && (st_reg.cnt < st_reg.act_duty_a);
				wave_b = st_reg.tog_b;
			end
			dcpwm_pkg::MODE_FREQ: begin
				wave_a = st_reg.tog_a;
				wave_b = st_reg.tog_b;
			end
			default: begin
				wave_a = 1'b0;
				wave_b = 1'b0;
			end
		endcase
	end

	always_comb begin
		st_next = st_reg;
		if (i_write) begin
			st_next.ctrl   = i_cfg.control;
			st_next.period = {i_cfg.period_high, i_cfg.period_low};
			st_next.duty_a = i_cfg.duty_a;
			st_next.duty_b = i_cfg.duty_b;
		end
		if (!act_run) begin
			// idle: take settings at once so that enabling starts a fresh period
			st_next.act_mode   = dcpwm_pkg::dcpwm_mode_t'(st_reg.ctrl[dcpwm_pkg::MODE_LSB +: 2]);
			st_next.act_div    = st_reg.ctrl[dcpwm_pkg::DIV_LSB +: 3];
			st_next.act_period = st_reg.period;
			st_next.act_duty_a = st_reg.duty_a;
			st_next.act_duty_b = st_reg.duty_b;
			st_next.pre        = 12'h000;
			st_next.cnt        = 16'h0000;
			st_next.cnt_b      = 16'h0000;
			st_next.tog_a      = 1'b0;
			st_next.tog_b      = 1'b0;
		end else if (i_base_tick) begin
			st_next.pre = gtick ? 12'h000 : st_reg.pre + 12'h001;
			if (gtick) begin
				st_next.cnt   = wrap_a ? 16'h0000 : st_reg.cnt + 16'h0001;
				st_next.cnt_b = wrap_b ? 16'h0000 : st_reg.cnt_b + 16'h0001;
				if (wrap_a) begin
					if (st_reg.act_mode == dcpwm_pkg::MODE_FREQ) begin
						st_next.tog_a = !st_reg.tog_a;
					end
					if (st_reg.act_mode == dcpwm_pkg::MODE_UNIV) begin
						st_next.tog_b = !st_reg.tog_b;
					end
					st_next.act_mode   = dcpwm_pkg::dcpwm_mode_t'(st_reg.ctrl[dcpwm_pkg::MODE_LSB +: 2]);
					st_next.act_div    = st_reg.ctrl[dcpwm_pkg::DIV_LSB +: 3];
					st_next.act_period = st_reg.period;
					st_next.act_duty_a = st_reg.duty_a;
					st_next.act_duty_b = st_reg.duty_b;
				end
				if (wrap_b && st_reg.act_mode == dcpwm_pkg::MODE_FREQ) begin
					st_next.tog_b = !st_reg.tog_b;
				end
			end
		end
		st_next.out_a   = !req_off && st_reg.ctrl[dcpwm_pkg::EN_A_BIT] && wave_a;
		st_next.out_b   = !req_off && st_reg.ctrl[dcpwm_pkg::EN_B_BIT] && wave_b;
		st_next.lockout = lock;
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			st_reg <= dcpwm_pkg::GROUP_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_out_a   = st_reg.out_a;
	assign o_out_b   = st_reg.out_b;
	assign o_lockout = st_reg.lockout;

	default clocking dcpwm_cb @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);

	mode_reset_a: assert property ($past(!i_reset_n) |-> st_reg.ctrl == dcpwm_pkg::CTRL_RESET
		&& st_reg.act_mode == dcpwm_pkg::MODE_SERVO && !st_reg.out_a && !st_reg.out_b)
		else $error("group not in servo mode with outputs low after reset");
	servo_width_a: assert property (st_reg.out_a && $past(st_reg.act_mode) == dcpwm_pkg::MODE_SERVO
		|-> $past(st_reg.cnt) < dcpwm_pkg::SERVO_MIN + dcpwm_pkg::SERVO_SPAN)
		else $error("servo pulse longer than its maximum");
	duty_indep_a: assert property ((st_reg.act_mode == dcpwm_pkg::MODE_DUTY && !req_off
		&& st_reg.ctrl[dcpwm_pkg::EN_B_BIT] && st_reg.act_period != 16'h0000)
		|=> st_reg.out_b == ($past(st_reg.cnt) < $past(st_reg.act_duty_b)))
		else $error("channel b duty does not follow its own word");
	univ_half_a: assert property ($changed(st_reg.tog_b) && $past(act_run)
		&& $past(st_reg.act_mode) == dcpwm_pkg::MODE_UNIV |-> $past(gtick && wrap_a))
		else $error("universal channel b toggled outside a period end");
	freq_toggle_a: assert property ($changed(st_reg.tog_a) && $past(act_run)
		|-> $past(gtick && wrap_a && st_reg.act_mode == dcpwm_pkg::MODE_FREQ))
		else $error("frequency channel a toggled outside its count end");
	enable_gate_a: assert property (!st_reg.ctrl[dcpwm_pkg::EN_A_BIT] |=> !st_reg.out_a)
		else $error("channel a active while disabled");
	write_take_a: assert property (i_write |=> st_reg.ctrl == $past(i_cfg.control)
		&& st_reg.period == {$past(i_cfg.period_high), $past(i_cfg.period_low)})
		else $error("exchange bytes not taken");
	div_off_a: assert property (st_reg.ctrl[dcpwm_pkg::DIV_LSB +: 3] == dcpwm_pkg::DIV_OFF
		|=> !st_reg.out_a && !st_reg.out_b)
		else $error("output active with divider off");
	lockout_a: assert property (lock |=> st_reg.lockout && !st_reg.out_a && !st_reg.out_b)
		else $error("frequency mode not refused with sensors active");
	prescale_a: assert property (act_run |-> st_reg.pre < target)
		else $error("prescale count past its target");
	load_edge_a: assert property ($changed(st_reg.act_period) && $past(act_run)
		|-> $past(gtick && wrap_a))
		else $error("period changed in the middle of a period");
	load_mode_a: assert property (($changed(st_reg.act_mode) || $changed(st_reg.act_duty_a))
		&& $past(act_run) |-> $past(gtick && wrap_a))
		else $error("mode or duty changed in the middle of a period");
	period_bound_a: assert property (act_run && (st_reg.act_mode == dcpwm_pkg::MODE_DUTY
		|| st_reg.act_mode == dcpwm_pkg::MODE_UNIV) && st_reg.act_period != 16'h0000
		|-> st_reg.cnt < st_reg.act_period)
		else $error("period count past the shared period word");
	freq_count_a: assert property (act_run && st_reg.act_mode == dcpwm_pkg::MODE_FREQ
		|-> st_reg.cnt == 16'h0000 || st_reg.cnt < st_reg.act_duty_a)
		else $error("frequency count follows the period word");
	servo_frame_a: assert property (act_run && st_reg.act_mode == dcpwm_pkg::MODE_SERVO
		|-> st_reg.cnt < dcpwm_pkg::SERVO_FRAME)
		else $error("servo count past its frame");
	univ_square_a: assert property (st_reg.act_mode == dcpwm_pkg::MODE_UNIV && !req_off
		&& st_reg.ctrl[dcpwm_pkg::EN_B_BIT] |=> st_reg.out_b == $past(st_reg.tog_b))
		else $error("universal channel b not the half rate square wave");
	channel_b_gate_a: assert property (!st_reg.ctrl[dcpwm_pkg::EN_B_BIT] |=> !st_reg.out_b)
		else $error("channel b active while disabled");

	servo_run_c: cover property (st_reg.act_mode == dcpwm_pkg::MODE_SERVO && $rose(st_reg.out_a));
	duty_run_c: cover property (st_reg.act_mode == dcpwm_pkg::MODE_DUTY && $fell(st_reg.out_b));
	univ_run_c: cover property (st_reg.act_mode == dcpwm_pkg::MODE_UNIV && $rose(st_reg.out_b));
	freq_lock_c: cover property ($rose(st_reg.lockout));
	freq_run_c: cover property (st_reg.act_mode == dcpwm_pkg::MODE_FREQ && $rose(st_reg.out_b));

endmodule // dcpwm_group

module dcpwm_top (
	// clock and reset
	input  wire logic                         i_clock,
	input  wire logic                         i_reset_n,
	// host exchange
	input  wire logic                         i_write,
	input  wire dcpwm_pkg::dcpwm_cfg_t [2:0]  i_group_cfg,
	input  wire logic [7:0]                   i_pin_setup_byte,
	// pulse outputs, bit 2g is channel a and 2g+1 channel b of group g
	output logic [5:0]                        o_pulse_channel,
	output logic [2:0]                        o_freq_lockout
);

	dcpwm_pkg::dcpwm_top_t st_reg;
	dcpwm_pkg::dcpwm_top_t st_next;
	logic                  sensor_any;

	assign sensor_any = |i_pin_setup_byte[dcpwm_pkg::SENSOR_LSB +: 4];

	// fractional divider: 16 base ticks every 50 clocks
	always_comb begin
		st_next      = st_reg;
		st_next.tick = ({1'b0, st_reg.acc} + {1'b0, dcpwm_pkg::TICK_STEP}) >= {1'b0, dcpwm_pkg::TICK_MOD};
		st_next.acc  = st_next.tick ? st_reg.acc + dcpwm_pkg::TICK_STEP - dcpwm_pkg::TICK_MOD
			: st_reg.acc + dcpwm_pkg::TICK_STEP;
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			st_reg <= dcpwm_pkg::TOP_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	default clocking dcpwm_top_cb @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);

	tick_single_a: assert property (st_reg.tick |=> !st_reg.tick)
		else $error("base tick lasts more than one clock");
	tick_rate_a: assert property (!st_reg.tick [*4] |=> st_reg.tick)
		else $error("base tick gap longer than four clocks");

	for (genvar g = 0; g < 3; g++) begin : gen_group
		dcpwm_group u_group (
			.i_clock      (i_clock),
			.i_reset_n    (i_reset_n),
			.i_base_tick  (st_reg.tick),
			.i_write      (i_write),
			.i_cfg        (i_group_cfg[g]),
			.i_sensor_any (sensor_any),
			.o_out_a      (o_pulse_channel[2 * g]),
			.o_out_b      (o_pulse_channel[2 * g + 1]),
			.o_lockout    (o_freq_lockout[g])
		);
	end

endmodule // dcpwm_top

`default_nettype wire

// ==== verification/dcpwm_host.sv ====
/*
 * host side model: drives the cyclic exchange bytes and the pin setup byte
 * assumes the bench calls its tasks after reset release; inputs change at falling edges
 */
`default_nettype none

module dcpwm_host (
	// clock
	input  wire logic                   i_clock,
	// exchange
	output logic                        o_write,
	output dcpwm_pkg::dcpwm_cfg_t [2:0] o_cfg,
	output logic [7:0]                  o_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_write = 1'b0;
		o_cfg = '0;
		o_pin = 8'h00;
	end

	// mode, period word, duties and enables travel together in one exchange
	task automatic send(input int g, input logic [7:0] c, input logic [15:0] p,
		input logic [15:0] a, input logic [15:0] b);
		@(negedge i_clock);
		o_cfg[g] = {c, p[7:0], p[15:8], a, b};
		o_write = 1'b1;
		@(negedge i_clock);
		o_write = 1'b0;
	endtask

	task automatic pin(input logic [7:0] v);
		@(negedge i_clock);
		o_pin = v;
	endtask
endmodule // dcpwm_host

`default_nettype wire

// ==== verification/dcpwm_top_tb.sv ====
/*
 * self-checking bench of the three pulse groups
 * assumes dcpwm_host drives the exchange; times are measured in 20 ns clocks
 */
`default_nettype none

module dcpwm_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                        clk;
	logic                        rst_n;
	logic                        wr;
	logic [7:0]                  pin;
	dcpwm_pkg::dcpwm_cfg_t [2:0] cfg;
	logic [5:0]                  pc;
	logic [2:0]                  lk;
	int                          error_cnt = 0;
	int                          compares = 0;

	dcpwm_host u_dcpwm_host (.i_clock(clk), .o_write(wr), .o_cfg(cfg), .o_pin(pin));
	dcpwm_top u_dcpwm_top (.i_clock(clk), .i_reset_n(rst_n), .i_write(wr), .i_group_cfg(cfg),
		.i_pin_setup_byte(pin), .o_pulse_channel(pc), .o_freq_lockout(lk));

	task automatic print_verdict();
		$display("checks %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %0d seen %0d", nm, e, s);
		end
	endtask

	// clocks of t ticks at divider d: t * 2 * d * 50 / 16
	function automatic logic [31:0] ck(input int t, input int d);
		return t * d * 25 / 4;
	endfunction

	function automatic int dv(input int c);
		return (c == 1) ? 1 : (c == 2) ? 8 : (c == 3) ? 64 : (c == 4) ? 256 : 1024;
	endfunction

	// tolerance of the fractional base tick
	function automatic logic [31:0] near(input logic [31:0] s, input logic [31:0] e);
		return (s + 3 >= e && s <= e + 3) ? e : s;
	endfunction

	// count clocks until channel i shows level v
	task automatic wl(input int i, input logic v, input int lim, output int n);
		n = 0;
		while (pc[i] !== v) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				error_cnt++;
				$display("Error wait on channel %0d", i);
				print_verdict();
			end
		end
	endtask

	task automatic meas(input int i, output int hi, output int lo);
		int n;
		wl(i, 1'b0, 70000, n);
		wl(i, 1'b1, 70000, n);
		wl(i, 1'b0, 70000, hi);
		wl(i, 1'b1, 70000, lo);
	endtask

	task automatic hc(input int i, output int h);
		h = 0;
		repeat (200) begin
			@(negedge clk);
			h += (pc[i] !== 1'b0);
		end
	endtask

	// stop the group first so the new settings start at once
	task automatic cfg_g(input int g, input logic [7:0] c, input int p, input int a, input int b);
		u_dcpwm_host.send(g, 8'h00, 16'h0000, 16'h0000, 16'h0000);
		u_dcpwm_host.send(g, c, 16'(p), 16'(a), 16'(b));
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		int s;
		int g;
		int p;
		int a;
		int b;
		int hi;
		int lo;
		int n;
		s = $urandom(47);
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk("outputs after reset", 32'(pc), 0);
		chk("lockout after reset", 32'(lk), 0);
		for (g = 0; g < 3; g++) begin
			p = $urandom_range(60, 20);
			a = $urandom_range(p - 1, 1);
			b = $urandom_range(p - 1, 1);
			cfg_g(g, 8'h39, p, a, b);
			meas(2 * g, hi, lo);
			chk("duty a high", near(hi, ck(a, 1)), ck(a, 1));
			chk("duty a low", near(lo, ck(p - a, 1)), ck(p - a, 1));
			meas(2 * g + 1, hi, lo);
			chk("duty b high", near(hi, ck(b, 1)), ck(b, 1));
			chk("duty b low", near(lo, ck(p - b, 1)), ck(p - b, 1));
		end
		$display("test duty done");
		for (int d = 1; d < 8; d++) begin
			cfg_g(0, {3'(d), 5'h09}, 2, 1, 0);
			wl(0, 1'b1, 8, n);
			wl(0, 1'b0, 70000, hi);
			chk("divider high", near(hi, ck(1, dv(d))), ck(1, dv(d)));
		end
		cfg_g(0, 8'h19, 2, 1, 0);
		hc(0, n);
		chk("divider off", n, 0);
		cfg_g(0, 8'h21, 2, 1, 0);
		hc(0, n);
		chk("enables clear", n, 0);
		$display("test divider done");
		b = $urandom_range(19, 1);
		cfg_g(1, 8'h3a, 20, 5, b);
		meas(2, hi, lo);
		chk("universal a high", near(hi, ck(5, 1)), ck(5, 1));
		chk("universal a low", near(lo, ck(15, 1)), ck(15, 1));
		meas(3, hi, lo);
		chk("universal b high", near(hi, ck(20, 1)), ck(20, 1));
		chk("universal b low", near(lo, ck(20, 1)), ck(20, 1));
		u_dcpwm_host.send(1, 8'h3a, 16'h0028, 16'h0005, 16'h0000);
		wl(2, 1'b1, 70000, n);
		meas(2, hi, lo);
		chk("reload a high", near(hi, ck(5, 1)), ck(5, 1));
		chk("reload a low", near(lo, ck(35, 1)), ck(35, 1));
		$display("test universal done");
		cfg_g(2, 8'h3b, $urandom_range(65535, 0), 8, 12);
		meas(4, hi, lo);
		chk("freq a high", near(hi, ck(8, 1)), ck(8, 1));
		chk("freq a low", near(lo, ck(8, 1)), ck(8, 1));
		meas(5, hi, lo);
		chk("freq b high", near(hi, ck(12, 1)), ck(12, 1));
		chk("freq b low", near(lo, ck(12, 1)), ck(12, 1));
		u_dcpwm_host.pin(8'h10 << $urandom_range(3, 0));
		repeat (4) @(negedge clk);
		chk("lockout set", 32'(lk), 4);
		hc(4, n);
		hc(5, hi);
		chk("lockout outputs", n + hi, 0);
		u_dcpwm_host.pin(8'h0f);
		repeat (4) @(negedge clk);
		chk("lockout clear", 32'(lk), 0);
		hc(4, n);
		chk("freq resumes", n > 0, 1);
		$display("test lockout done");
		cfg_g(0, 8'hf8, 0, 0, 0);
		wl(1, 1'b1, 8, n);
		wl(1, 1'b0, 70000, hi);
		chk("servo pulse", near(hi, dcpwm_pkg::SERVO_MIN * 50), dcpwm_pkg::SERVO_MIN * 50);
		$display("test servo done");
		print_verdict();
	end
endmodule // dcpwm_top_tb

`default_nettype wire
